// File: hdl/dtsr_regs.v
// Summary of operation
// (RULE_01) Word 0x20 reads back the read-to-read and read-to-write spacings in five six-bit fields.
// (RULE_02) Word 0x21 reads back the mixed read/write and precharge timings in five six-bit fields.
// (RULE_03) Word 0x22 reads back the write-to-write, write-to-read and write-to-precharge timings.
// (RULE_04) Word 0x23 reads back precharge, refresh (eight bits) and power-down timings.
// (RULE_05) Word 0x28 reads back the eight-bit four-activate window.
// (RULE_06) Word 0x2A reads back the column, row, bank, bank group and chip select address widths.
// (RULE_07) Bit 0 of word 0x2B requests a mode register command and clears itself when it completes.
// (RULE_08) Software sets up the mode register command words 0x37 and 0x38 before requesting it.
// (RULE_09) Software reads word 0x31 for the status of a mode register command.
// (RULE_10) Bits 3:0 of word 0x2C request per-rank refreshes and each clears once its refresh is issued.
// (RULE_11) Bit 0 of word 0x2D requests a long ZQ calibration and clears once it has run.
// (RULE_12) Bit 0 of word 0x31 is high while a mode register command is in progress.
// (RULE_13) Timing fields count controller cycles and writes to read-only words change nothing.
`include "dtsr_defines.vh"

module dtsr_regs (
  // Clock and reset
  input  wire                     pclk,
  input  wire                     presetn,
  // APB slave
  input  wire                     psel,
  input  wire                     penable,
  input  wire                     pwrite,
  input  wire [`DTSR_AW-1:0]      paddr,
  input  wire [`DTSR_DW-1:0]      pwdata,
  output wire                     pready,
  output wire [`DTSR_DW-1:0]      prdata,
  output wire                     pslverr,
  // Read spacing timings
  input  wire [`DTSR_T6_W-1:0]    read_read_same_bank_field,
  input  wire [`DTSR_T6_W-1:0]    read_read_diff_chip_field,
  input  wire [`DTSR_T6_W-1:0]    read_read_diff_bg_field,
  input  wire [`DTSR_T6_W-1:0]    read_write_same_bank_field,
  input  wire [`DTSR_T6_W-1:0]    read_write_diff_chip_field,
  // Mixed read/write timings
  input  wire [`DTSR_T6_W-1:0]    read_write_diff_bg_field,
  input  wire [`DTSR_T6_W-1:0]    read_precharge_field,
  input  wire [`DTSR_T6_W-1:0]    read_autopch_valid_field,
  input  wire [`DTSR_T6_W-1:0]    write_write_same_bank_field,
  input  wire [`DTSR_T6_W-1:0]    write_write_diff_chip_field,
  // Write spacing timings
  input  wire [`DTSR_T6_W-1:0]    write_write_diff_bg_field,
  input  wire [`DTSR_T6_W-1:0]    write_read_field,
  input  wire [`DTSR_T6_W-1:0]    write_read_diff_chip_field,
  input  wire [`DTSR_T6_W-1:0]    write_read_diff_bg_field,
  input  wire [`DTSR_T6_W-1:0]    write_precharge_field,
  // Precharge and refresh timings
  input  wire [`DTSR_T6_W-1:0]    write_autopch_valid_field,
  input  wire [`DTSR_T6_W-1:0]    precharge_valid_field,
  input  wire [`DTSR_T6_W-1:0]    precharge_all_valid_field,
  input  wire [`DTSR_T8_W-1:0]    auto_refresh_to_valid_field,
  input  wire [`DTSR_T6_W-1:0]    power_down_to_valid_field,
  // Four-activate window
  input  wire [`DTSR_T8_W-1:0]    four_activate_window_field,
  // Address widths
  input  wire [4:0]               col_addr_width,
  input  wire [4:0]               row_addr_width,
  input  wire [3:0]               bank_addr_width,
  input  wire [1:0]               bank_group_addr_width,
  input  wire [2:0]               cs_addr_width,
  // Mode register command
  output wire                     mode_reg_cmd_req_bit,
  input  wire                     mode_reg_cmd_done,
  input  wire                     mode_reg_cmd_busy,
  // Rank refresh
  output wire [`DTSR_RANKS-1:0]   rank_refresh_req,
  input  wire [`DTSR_RANKS-1:0]   rank_refresh_done,
  // Long ZQ calibration
  output wire                     long_zq_cal_req,
  input  wire                     long_zq_cal_done
);

  wire [`DTSR_IDX_W-1:0] idx;
  wire                   aligned;
  wire                   wr_en;
  wire                   wr_mrc;
  wire                   wr_ref;
  wire                   wr_zql;
  reg  [`DTSR_DW-1:0]    rd_word;
  reg                    rd_hit;
  reg  [`DTSR_DW-1:0]    w_rd_spacing;
  reg  [`DTSR_DW-1:0]    w_rw_mixed;
  reg  [`DTSR_DW-1:0]    w_wr_spacing;
  reg  [`DTSR_DW-1:0]    w_pch_ref;
  reg  [`DTSR_DW-1:0]    w_faw;
  reg  [`DTSR_DW-1:0]    w_addr_w;
  reg  [`DTSR_DW-1:0]    w_mrc_req;
  reg  [`DTSR_DW-1:0]    w_ref_req;
  reg  [`DTSR_DW-1:0]    w_zql_req;
  reg  [`DTSR_DW-1:0]    w_mrc_stat;

  assign idx     = paddr[`DTSR_ADDR_IDX];
  assign aligned = (paddr[`DTSR_ADDR_LANE] == `DTSR_LANE_ALIGNED);

  // Only the three request words take writes
  assign wr_mrc = wr_en & aligned & (idx == `DTSR_IDX_MRC_REQ); // RULE_13
  assign wr_ref = wr_en & aligned & (idx == `DTSR_IDX_REF_REQ); // RULE_13
  assign wr_zql = wr_en & aligned & (idx == `DTSR_IDX_ZQL_REQ); // RULE_13

  dtsr_apb_if u_apb (
    .clk       (pclk),
    .rstn      (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .rd_word   (rd_word),
    .rd_hit    (rd_hit),
    .pready    (pready),
    .prdata_r  (prdata),
    .pslverr_r (pslverr),
    .wr_en     (wr_en)
  );

  // Mode register command request
  dtsr_req_bits #(
    .W (1)
  ) u_mrc (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_mrc),
    .wr_data (pwdata[`DTSR_REQ1]), // RULE_07
    .done    (mode_reg_cmd_done), // RULE_07
    .req_r   (mode_reg_cmd_req_bit)
  );

  // Per-rank refresh requests
  dtsr_req_bits #(
    .W (`DTSR_RANKS)
  ) u_ref (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_ref),
    .wr_data (pwdata[`DTSR_REF_BITS]), // RULE_10
    .done    (rank_refresh_done), // RULE_10
    .req_r   (rank_refresh_req)
  );

  // Long ZQ calibration request
  dtsr_req_bits #(
    .W (1)
  ) u_zql (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_zql),
    .wr_data (pwdata[`DTSR_REQ1]), // RULE_11
    .done    (long_zq_cal_done), // RULE_11
    .req_r   (long_zq_cal_req)
  );

  // Read spacing word, unused bits zero, timings in controller cycles
  always @*
  begin
    w_rd_spacing = `DTSR_WORD_ZERO;
    w_rd_spacing[`DTSR_F0] = read_read_same_bank_field; // RULE_01
    w_rd_spacing[`DTSR_F1] = read_read_diff_chip_field; // RULE_01
    w_rd_spacing[`DTSR_F2] = read_read_diff_bg_field; // RULE_01
    w_rd_spacing[`DTSR_F3] = read_write_same_bank_field; // RULE_01
    w_rd_spacing[`DTSR_F4] = read_write_diff_chip_field; // RULE_01
  end

  // Mixed read/write word
  always @*
  begin
    w_rw_mixed = `DTSR_WORD_ZERO;
    w_rw_mixed[`DTSR_F0] = read_write_diff_bg_field; // RULE_02
    w_rw_mixed[`DTSR_F1] = read_precharge_field; // RULE_02
    w_rw_mixed[`DTSR_F2] = read_autopch_valid_field; // RULE_02
    w_rw_mixed[`DTSR_F3] = write_write_same_bank_field; // RULE_02
    w_rw_mixed[`DTSR_F4] = write_write_diff_chip_field; // RULE_02
  end

  // Write spacing word
  always @*
  begin
    w_wr_spacing = `DTSR_WORD_ZERO;
    w_wr_spacing[`DTSR_F0] = write_write_diff_bg_field; // RULE_03
    w_wr_spacing[`DTSR_F1] = write_read_field; // RULE_03
    w_wr_spacing[`DTSR_F2] = write_read_diff_chip_field; // RULE_03
    w_wr_spacing[`DTSR_F3] = write_read_diff_bg_field; // RULE_03
    w_wr_spacing[`DTSR_F4] = write_precharge_field; // RULE_03
  end

  // Precharge and refresh word, all 32 bits used
  always @*
  begin
    w_pch_ref = `DTSR_WORD_ZERO;
    w_pch_ref[`DTSR_F0] = write_autopch_valid_field; // RULE_04
    w_pch_ref[`DTSR_F1] = precharge_valid_field; // RULE_04
    w_pch_ref[`DTSR_F2] = precharge_all_valid_field; // RULE_04
    w_pch_ref[`DTSR_ARF] = auto_refresh_to_valid_field; // RULE_04
    w_pch_ref[`DTSR_PDN] = power_down_to_valid_field; // RULE_04
  end

  // Four-activate window word
  always @*
  begin
    w_faw = `DTSR_WORD_ZERO;
    w_faw[`DTSR_FAW] = four_activate_window_field; // RULE_05
  end

  // Address width word
  always @*
  begin
    w_addr_w = `DTSR_WORD_ZERO;
    w_addr_w[`DTSR_COL] = col_addr_width; // RULE_06
    w_addr_w[`DTSR_ROW] = row_addr_width; // RULE_06
    w_addr_w[`DTSR_BANK] = bank_addr_width; // RULE_06
    w_addr_w[`DTSR_BG] = bank_group_addr_width; // RULE_06
    w_addr_w[`DTSR_CS] = cs_addr_width; // RULE_06
  end

  // Mode register command request word
  always @*
  begin
    w_mrc_req = `DTSR_WORD_ZERO;
    w_mrc_req[`DTSR_REQ1] = mode_reg_cmd_req_bit; // RULE_07
  end

  // Rank refresh request word
  always @*
  begin
    w_ref_req = `DTSR_WORD_ZERO;
    w_ref_req[`DTSR_REF_BITS] = rank_refresh_req; // RULE_10
  end

  // Long calibration request word
  always @*
  begin
    w_zql_req = `DTSR_WORD_ZERO;
    w_zql_req[`DTSR_REQ1] = long_zq_cal_req; // RULE_11
  end

  // Mode register command status word
  always @*
  begin
    w_mrc_stat = `DTSR_WORD_ZERO;
    w_mrc_stat[`DTSR_REQ1] = mode_reg_cmd_busy; // RULE_12
  end

  // Index hit, unmapped or unaligned addresses answer with an error
  always @*
  begin
    rd_hit = 1'b0;
    case (idx)
      `DTSR_IDX_RD_SPACING,
      `DTSR_IDX_RW_MIXED,
      `DTSR_IDX_WR_SPACING,
      `DTSR_IDX_PCH_REF,
      `DTSR_IDX_FAW,
      `DTSR_IDX_ADDR_W,
      `DTSR_IDX_MRC_REQ,
      `DTSR_IDX_REF_REQ,
      `DTSR_IDX_ZQL_REQ,
      `DTSR_IDX_MRC_STAT:
        rd_hit = aligned;
      default:
        rd_hit = 1'b0;
    endcase
  end

  // Read word select
  always @*
  begin
    rd_word = `DTSR_WORD_ZERO;
    case (idx)
      `DTSR_IDX_RD_SPACING:
      begin
        rd_word = w_rd_spacing;
      end
      `DTSR_IDX_RW_MIXED:
      begin
        rd_word = w_rw_mixed;
      end
      `DTSR_IDX_WR_SPACING:
      begin
        rd_word = w_wr_spacing;
      end
      `DTSR_IDX_PCH_REF:
      begin
        rd_word = w_pch_ref;
      end
      `DTSR_IDX_FAW:
      begin
        rd_word = w_faw;
      end
      `DTSR_IDX_ADDR_W:
      begin
        rd_word = w_addr_w;
      end
      `DTSR_IDX_MRC_REQ:
      begin
        rd_word = w_mrc_req;
      end
      `DTSR_IDX_REF_REQ:
      begin
        rd_word = w_ref_req;
      end
      `DTSR_IDX_ZQL_REQ:
      begin
        rd_word = w_zql_req;
      end
      `DTSR_IDX_MRC_STAT:
      begin
        rd_word = w_mrc_stat; // RULE_09
      end
      default:
        rd_word = `DTSR_WORD_ZERO;
    endcase
    if (!aligned)
      rd_word = `DTSR_WORD_ZERO;
  end

endmodule

// File: hdl/dtsr_defines.vh
`ifndef DTSR_DEFINES_VH
`define DTSR_DEFINES_VH

// Bus geometry
`define DTSR_AW               8
`define DTSR_DW               32
`define DTSR_WORD_ZERO        32'h0000_0000
`define DTSR_IDX_W            6
`define DTSR_ADDR_IDX         7:2
`define DTSR_ADDR_LANE        1:0
`define DTSR_LANE_ALIGNED     2'h0

// Register indices, byte address is four times the index
`define DTSR_IDX_RD_SPACING   6'h20
`define DTSR_IDX_RW_MIXED     6'h21
`define DTSR_IDX_WR_SPACING   6'h22
`define DTSR_IDX_PCH_REF      6'h23
`define DTSR_IDX_FAW          6'h28
`define DTSR_IDX_ADDR_W       6'h2A
`define DTSR_IDX_MRC_REQ      6'h2B
`define DTSR_IDX_REF_REQ      6'h2C
`define DTSR_IDX_ZQL_REQ      6'h2D
`define DTSR_IDX_MRC_STAT     6'h31

// Common five-slot layout of timing words
`define DTSR_F0               5:0
`define DTSR_F1               11:6
`define DTSR_F2               17:12
`define DTSR_F3               23:18
`define DTSR_F4               29:24
`define DTSR_T6_W             6

// Precharge/refresh word extras
`define DTSR_ARF              25:18
`define DTSR_PDN              31:26
`define DTSR_T8_W             8

// Four-activate window
`define DTSR_FAW              7:0

// Address width word
`define DTSR_COL              4:0
`define DTSR_ROW              9:5
`define DTSR_BANK             13:10
`define DTSR_BG               15:14
`define DTSR_CS               18:16

// Request bits
`define DTSR_REQ1             0:0
`define DTSR_REF_BITS         3:0
`define DTSR_RANKS            4
`define DTSR_REQ1_RST         1'h0
`define DTSR_REF_RST          4'h0

`endif

// File: hdl/dtsr_req_bits.v
`include "dtsr_defines.vh"

module dtsr_req_bits #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // Software write
  input  wire         wr_en,
  input  wire [W-1:0] wr_data,
  // Controller completion
  input  wire [W-1:0] done,
  // Request level
  output reg  [W-1:0] req_r
);

  wire [W-1:0] req_nxt;

  // A software write overrides a same-cycle completion
  assign req_nxt = wr_en ? wr_data : (req_r & ~done);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      req_r <= {W{1'b0}};
    else
      req_r <= req_nxt;
  end

endmodule

// File: hdl/dtsr_apb_if.v
`include "dtsr_defines.vh"

module dtsr_apb_if (
  // Clock and reset
  input  wire                clk,
  input  wire                rstn,
  // APB request
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  // Decoded read data from the bank
  input  wire [`DTSR_DW-1:0] rd_word,
  input  wire                rd_hit,
  // APB answer
  output wire                pready,
  output reg  [`DTSR_DW-1:0] prdata_r,
  output reg                 pslverr_r,
  // Strobes to the bank
  output wire                wr_en
);

  wire setup;

  assign setup  = psel & ~penable;
  assign pready = psel & penable;
  assign wr_en  = psel & penable & pwrite;

  // Read word and error captured in the setup cycle
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata_r  <= `DTSR_WORD_ZERO;
      pslverr_r <= 1'b0;
    end
    else if (setup)
    begin
      prdata_r  <= pwrite ? `DTSR_WORD_ZERO : rd_word;
      pslverr_r <= ~rd_hit;
    end
  end

endmodule

// File: bench/dtsr_ctrl_model.sv
module dtsr_ctrl_model (
  // Clock, reset, service time
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] lat,
  // Requests
  input  wire logic       mrc_req,
  input  wire logic [3:0] ref_req,
  input  wire logic       zq_req,
  // Completions
  output logic            mrc_done,
  output logic            mrc_busy,
  output logic [3:0]      ref_done,
  output logic            zq_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       busy_r;
  logic [3:0] cnt_r;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      busy_r   <= 1'b0;
      cnt_r    <= 4'h0;
      mrc_busy <= 1'b0;
      mrc_done <= 1'b0;
      ref_done <= 4'h0;
      zq_done  <= 1'b0;
    end
    else
    begin
      mrc_done <= 1'b0;
      ref_done <= 4'h0;
      zq_done  <= 1'b0;
      // No restart while a completion is still visible
      if (!busy_r && (mrc_req || |ref_req || zq_req) && !(mrc_done || |ref_done || zq_done))
      begin
        busy_r   <= 1'b1;
        mrc_busy <= mrc_req;
        cnt_r    <= lat;
      end
      else if (busy_r && cnt_r == 4'h0)
      begin
        busy_r   <= 1'b0;
        mrc_busy <= 1'b0;
        mrc_done <= mrc_req;
        ref_done <= ref_req;
        zq_done  <= zq_req;
      end
      else if (busy_r)
        cnt_r <= cnt_r - 4'h1;
    end
endmodule

// File: bench/dtsr_regs_asserts.sv
module dtsr_regs_asserts (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  // Sideband
  input wire logic        mode_reg_cmd_req_bit,
  input wire logic        mode_reg_cmd_done,
  input wire logic        mode_reg_cmd_busy,
  input wire logic [3:0]  rank_refresh_req,
  input wire logic [3:0]  rank_refresh_done,
  input wire logic        long_zq_cal_req,
  input wire logic        long_zq_cal_done,
  input wire logic [7:0]  four_activate_window_field
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pwrite && pready;
  wire rs  = psel && !penable && !pwrite;
  wire wm  = acc && paddr == 8'hAC;
  wire wr  = acc && paddr == 8'hB0;
  wire wz  = acc && paddr == 8'hB4;
  property p_faw; rs && paddr == 8'hA0 |=> prdata == {24'h0, $past(four_activate_window_field)}; endproperty
  a_faw: assert property (p_faw) else $error("window read wrong");
  property p_stat; rs && paddr == 8'hC4 |=> prdata == {31'h0, $past(mode_reg_cmd_busy)}; endproperty
  a_stat: assert property (p_stat) else $error("status read wrong");
  property p_mset; wm |=> mode_reg_cmd_req_bit == $past(pwdata[0]); endproperty
  a_mset: assert property (p_mset) else $error("mode request not loaded");
  property p_mclr; mode_reg_cmd_done && !wm |=> !mode_reg_cmd_req_bit; endproperty
  a_mclr: assert property (p_mclr) else $error("mode request not cleared");
  property p_rset; wr |=> rank_refresh_req == $past(pwdata[3:0]); endproperty
  a_rset: assert property (p_rset) else $error("refresh request not loaded");
  property p_rclr; !wr |=> (rank_refresh_req & $past(rank_refresh_done)) == 4'h0; endproperty
  a_rclr: assert property (p_rclr) else $error("refresh request not cleared");
  property p_zset; wz |=> long_zq_cal_req == $past(pwdata[0]); endproperty
  a_zset: assert property (p_zset) else $error("calibration request not loaded");
  property p_zclr; long_zq_cal_done && !wz |=> !long_zq_cal_req; endproperty
  a_zclr: assert property (p_zclr) else $error("calibration request not cleared");
endmodule

bind dtsr_regs dtsr_regs_asserts dtsr_regs_asserts_inst (
  .pclk                       (pclk),
  .presetn                    (presetn),
  .psel                       (psel),
  .penable                    (penable),
  .pwrite                     (pwrite),
  .paddr                      (paddr),
  .pwdata                     (pwdata),
  .pready                     (pready),
  .prdata                     (prdata),
  .mode_reg_cmd_req_bit       (mode_reg_cmd_req_bit),
  .mode_reg_cmd_done          (mode_reg_cmd_done),
  .mode_reg_cmd_busy          (mode_reg_cmd_busy),
  .rank_refresh_req           (rank_refresh_req),
  .rank_refresh_done          (rank_refresh_done),
  .long_zq_cal_req            (long_zq_cal_req),
  .long_zq_cal_done           (long_zq_cal_done),
  .four_activate_window_field (four_activate_window_field)
);

// File: bench/dtsr_regs_tb.sv
module dtsr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        mode_reg_cmd_req_bit, mode_reg_cmd_done, mode_reg_cmd_busy, long_zq_cal_req, long_zq_cal_done;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  lat, rank_refresh_req, rank_refresh_done;
  int          fails, tests_run;
  logic [31:0] t  [0:5] = '{32'h1E3C_5A96, 32'h2B4D_6F81, 32'h0F1E_2D3C, 32'hB7D5_E3F1, 32'hA5, 32'h5_6B29};
  logic [7:0]  ra [0:5] = '{8'h80, 8'h84, 8'h88, 8'h8C, 8'hA0, 8'hA8};
  logic [7:0]  qa [0:6] = '{8'hAC, 8'hB0, 8'hB0, 8'hB0, 8'hB0, 8'hB0, 8'hB4};
  logic [3:0]  qv [0:6] = '{4'h1, 4'h1, 4'h2, 4'h4, 4'h8, 4'hF, 4'h1};
  wire         any_req = mode_reg_cmd_req_bit | (|rank_refresh_req) | long_zq_cal_req;
  dtsr_regs dtsr_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .read_read_same_bank_field(t[0][5:0]), .read_read_diff_chip_field(t[0][11:6]),
    .read_read_diff_bg_field(t[0][17:12]), .read_write_same_bank_field(t[0][23:18]),
    .read_write_diff_chip_field(t[0][29:24]), .read_write_diff_bg_field(t[1][5:0]),
    .read_precharge_field(t[1][11:6]), .read_autopch_valid_field(t[1][17:12]),
    .write_write_same_bank_field(t[1][23:18]), .write_write_diff_chip_field(t[1][29:24]),
    .write_write_diff_bg_field(t[2][5:0]), .write_read_field(t[2][11:6]), .write_read_diff_chip_field(t[2][17:12]),
    .write_read_diff_bg_field(t[2][23:18]), .write_precharge_field(t[2][29:24]),
    .write_autopch_valid_field(t[3][5:0]), .precharge_valid_field(t[3][11:6]),
    .precharge_all_valid_field(t[3][17:12]), .auto_refresh_to_valid_field(t[3][25:18]),
    .power_down_to_valid_field(t[3][31:26]), .four_activate_window_field(t[4][7:0]),
    .col_addr_width(t[5][4:0]), .row_addr_width(t[5][9:5]), .bank_addr_width(t[5][13:10]),
    .bank_group_addr_width(t[5][15:14]), .cs_addr_width(t[5][18:16]),
    .mode_reg_cmd_req_bit(mode_reg_cmd_req_bit), .mode_reg_cmd_done(mode_reg_cmd_done),
    .mode_reg_cmd_busy(mode_reg_cmd_busy), .rank_refresh_req(rank_refresh_req),
    .rank_refresh_done(rank_refresh_done), .long_zq_cal_req(long_zq_cal_req), .long_zq_cal_done(long_zq_cal_done));
  dtsr_ctrl_model dtsr_ctrl_model_inst (.pclk(pclk), .presetn(presetn), .lat(lat), .mrc_req(mode_reg_cmd_req_bit),
    .ref_req(rank_refresh_req), .zq_req(long_zq_cal_req), .mrc_done(mode_reg_cmd_done),
    .mrc_busy(mode_reg_cmd_busy), .ref_done(rank_refresh_done), .zq_done(long_zq_cal_done));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && ++n < 64);
    if (pready !== 1'b1)
    begin
      fails++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
    xfer(1'b0, a, 32'h0);
    chk("prdata", e, rd);
    chk("pslverr", {31'h0, ee}, {31'h0, er});
  endtask
  task automatic drain(input logic [7:0] a);
    int n;
    n = 0;
    while (any_req !== 1'b0 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    rdc(a, 32'h0, 1'b0);
    rdc(8'hC4, 32'h0, 1'b0);
  endtask
  task automatic complete_run();
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    complete_run();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    lat = 4'h8;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      rdc(ra[i], t[i], 1'b0);
      xfer(1'b1, ra[i], 32'hFFFF_FFFF);
      t[i] <= t[i] >> 1;
      rdc(ra[i], t[i] >> 1, 1'b0);
    end
    rdc(8'h00, 32'h0, 1'b1);
    rdc(8'h81, 32'h0, 1'b1);
    // Setup words sit outside this bank and answer with an error
    xfer(1'b1, 8'hDC, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    xfer(1'b1, 8'hE0, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    for (int i = 0; i < 7; i++)
    begin
      xfer(1'b1, qa[i], {28'h0, qv[i]});
      rdc(qa[i], {28'h0, qv[i]}, 1'b0);
      rdc(8'hC4, {31'h0, qa[i] == 8'hAC}, 1'b0);
      drain(qa[i]);
    end
    // Second write lands on the completion edge, the write must win
    lat <= 4'h0;
    xfer(1'b1, 8'hB4, 32'h1);
    xfer(1'b1, 8'hB4, 32'h1);
    rdc(8'hB4, 32'h1, 1'b0);
    drain(8'hB4);
    lat <= 4'hF;
    xfer(1'b1, 8'hB0, 32'h5);
    xfer(1'b1, 8'hB0, 32'h0);
    rdc(8'hB0, 32'h0, 1'b0);
    // Reset in mid-run drops a pending request
    xfer(1'b1, 8'hAC, 32'h1);
    presetn <= 1'b0;
    @(posedge pclk);
    chk("reset requests", 32'h0, {26'h0, mode_reg_cmd_req_bit, rank_refresh_req, long_zq_cal_req});
    presetn <= 1'b1;
    rdc(8'hAC, 32'h0, 1'b0);
    rdc(8'hC4, 32'h0, 1'b0);
    complete_run();
  end
endmodule
